// ### nv_access_pkg.sv
package nv_access_pkg;
    localparam int CLK_PERIOD_NS = 10;
    // programming is timed in oscillator ticks, each divided down from OSC_DIV_CYCLES (100) pclk cycles
    localparam int OSC_TICK_NS = 1000;
    localparam int OSC_DIV_CYCLES = OSC_TICK_NS / CLK_PERIOD_NS;
    localparam real ERASE_WRITE_TIME_MS = 3.4;
    localparam real SPLIT_TIME_MS = 1.8;
    localparam int ERASE_WRITE_TICKS = int'(ERASE_WRITE_TIME_MS * 1.0e6 / OSC_TICK_NS);
    localparam int SPLIT_TICKS = int'(SPLIT_TIME_MS * 1.0e6 / OSC_TICK_NS);
    localparam int TICK_WIDTH = 12;
    localparam int READ_STALL_CYCLES = 4;
    localparam int PROG_STALL_CYCLES = 2;
    localparam int ARM_WINDOW_CYCLES = 4;
    localparam int MEM_BYTES_DEFAULT = 512;
    localparam logic [7:0] IDX_CTRL = 8'h1c;
    localparam logic [7:0] IDX_DATA = 8'h1d;
    localparam logic [7:0] IDX_ADDR_LOW = 8'h1e;
    localparam logic [7:0] IDX_ADDR_HIGH = 8'h1f;
    localparam logic [7:0] ADDR_CTRL = 8'(IDX_CTRL * 4);
    localparam logic [7:0] ADDR_DATA = 8'(IDX_DATA * 4);
    localparam logic [7:0] ADDR_LOW = 8'(IDX_ADDR_LOW * 4);
    localparam logic [7:0] ADDR_HIGH = 8'(IDX_ADDR_HIGH * 4);
    localparam int CTRL_READ_BIT = 0;
    localparam int CTRL_START_BIT = 1;
    localparam int CTRL_ARM_BIT = 2;
    localparam int CTRL_IRQ_EN_BIT = 3;
    localparam int CTRL_MODE_LSB = 4;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    typedef enum logic [1:0] {
        mode_erase_write = 2'b00,
        mode_erase_only = 2'b01,
        mode_write_only = 2'b10,
        mode_reserved = 2'b11
    } program_mode_type;
    typedef enum logic [1:0] {
        bus_idle = 2'b00,
        bus_stall = 2'b01,
        bus_ready = 2'b11
    } bus_state_type;
endpackage : nv_access_pkg

// ### nv_osc_tick.sv
`timescale 1ns/100ps
module nv_osc_tick import nv_access_pkg::*; #(
    parameter int DIV = OSC_DIV_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    output logic tick
);
    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
    logic [CW-1:0] count;
    logic [CW-1:0] next_count;
    logic next_tick;

    always_comb begin
        next_tick = 1'b0;
        next_count = count - 1'b1;
        if (count == '0) begin
            next_count = CW'(DIV - 1);
            next_tick = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= '0;
            tick <= 1'b0;
        end else begin
            count <= next_count;
            tick <= next_tick;
        end
    end
endmodule : nv_osc_tick

// ### nv_byte_array.sv
`timescale 1ns/100ps
module nv_byte_array import nv_access_pkg::*; #(
    parameter int DEPTH = MEM_BYTES_DEFAULT,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic pclk,
    input wire logic commit,
    input wire program_mode_type op_mode,
    input wire logic [AW-1:0] op_addr,
    input wire logic [7:0] op_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [7:0] rd_data
);
    // no reset: the contents are meant to survive it
    logic [7:0] cells [DEPTH];
    logic [7:0] new_byte;

    always_comb begin
        rd_data = cells[rd_addr];
        case (op_mode)
            mode_erase_write: new_byte = op_data;
            mode_erase_only: new_byte = ERASED_BYTE;
            mode_write_only: new_byte = cells[op_addr] & op_data;
            default: new_byte = cells[op_addr];
        endcase
    end

    always_ff @(posedge pclk) begin
        if (commit) begin
            cells[op_addr] <= new_byte;
        end
    end
endmodule : nv_byte_array

// ### eeprom_byte_access_control.sv
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/100ps
module eeprom_byte_access_control import nv_access_pkg::*; #(
    parameter int MEM_BYTES = MEM_BYTES_DEFAULT,
    parameter int ADDR_WIDTH = $clog2(MEM_BYTES),
    parameter int OSC_DIV = OSC_DIV_CYCLES,
    parameter int ATOMIC_TICKS = ERASE_WRITE_TICKS,
    parameter int SPLIT_OP_TICKS = SPLIT_TICKS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic global_irq_enable,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    output logic ready_irq
);
    function automatic logic is_mapped(input logic [7:0] a);
        return (a == ADDR_CTRL) || (a == ADDR_DATA) || (a == ADDR_LOW) || (a == ADDR_HIGH);
    endfunction : is_mapped

    bus_state_type state;
    bus_state_type next_state;
    logic [2:0] stall_cnt;
    logic [2:0] next_stall_cnt;
    logic next_pready;
    logic [31:0] next_prdata;
    logic next_pslverr;
    logic read_pend;
    logic next_read_pend;
    logic start_pend;
    logic next_start_pend;

    logic [ADDR_WIDTH-1:0] nv_byte_address_reg;
    logic [ADDR_WIDTH-1:0] next_address;
    logic [7:0] nv_byte_data_reg;
    logic [7:0] next_data;
    program_mode_type program_mode_select;
    program_mode_type next_mode;
    logic ready_irq_enable;
    logic next_irq_enable;
    logic [2:0] arm_cnt;
    logic [2:0] next_arm_cnt;
    logic program_start_busy;
    logic next_busy;
    logic [TICK_WIDTH-1:0] tick_cnt;
    logic [TICK_WIDTH-1:0] next_tick_cnt;
    program_mode_type op_mode;
    program_mode_type next_op_mode;
    logic [ADDR_WIDTH-1:0] op_addr;
    logic [ADDR_WIDTH-1:0] next_op_addr;
    logic [7:0] op_data;
    logic [7:0] next_op_data;
    logic next_ready_irq;

    logic program_arm_enable;
    logic setup;
    logic done;
    logic ctrl_setup;
    logic read_ok;
    logic start_ok;
    logic osc_tick;
    logic commit;
    logic [7:0] mem_rd_data;
    logic [15:0] addr_ext;
    logic [7:0] nv_access_control_reg;

    assign program_arm_enable = (arm_cnt != 3'h0);
    assign setup = psel && !penable;
    assign done = psel && penable && pready;
    assign addr_ext = 16'(nv_byte_address_reg);
    assign nv_access_control_reg = {2'b00, program_mode_select, ready_irq_enable, program_arm_enable,
                                    program_start_busy, 1'b0};
    assign ctrl_setup = setup && pwrite && (paddr == ADDR_CTRL);
    assign read_ok = ctrl_setup && pwdata[CTRL_READ_BIT] && !program_start_busy;
    assign start_ok = ctrl_setup && pwdata[CTRL_START_BIT] && program_arm_enable && !program_start_busy
                      && (pwdata[CTRL_MODE_LSB+1:CTRL_MODE_LSB] != mode_reserved);
    assign commit = program_start_busy && osc_tick && (tick_cnt == TICK_WIDTH'(1));

    nv_osc_tick #(
        .DIV(OSC_DIV)
    ) u_osc_tick (
        .pclk(pclk),
        .presetn(presetn),
        .tick(osc_tick)
    );

    nv_byte_array #(
        .DEPTH(MEM_BYTES),
        .AW(ADDR_WIDTH)
    ) u_byte_array (
        .pclk(pclk),
        .commit(commit),
        .op_mode(op_mode),
        .op_addr(op_addr),
        .op_data(op_data),
        .rd_addr(nv_byte_address_reg),
        .rd_data(mem_rd_data)
    );

    // bus side: stall length is decided at setup so the arm window is judged there
    always_comb begin
        next_state = state;
        next_stall_cnt = stall_cnt;
        next_prdata = prdata;
        next_pslverr = pslverr;
        next_read_pend = read_pend;
        next_start_pend = start_pend;
        case (state)
            bus_idle: begin
                if (setup) begin
                    next_read_pend = read_ok;
                    next_start_pend = start_ok;
                    next_pslverr = !is_mapped(paddr);
                    next_stall_cnt = 3'h0;
                    next_state = bus_ready;
                    if (read_ok) begin
                        next_stall_cnt = 3'(READ_STALL_CYCLES);
                        next_state = bus_stall;
                    end else if (start_ok) begin
                        next_stall_cnt = 3'(PROG_STALL_CYCLES);
                        next_state = bus_stall;
                    end
                    case (paddr)
                        ADDR_LOW: next_prdata = {24'h0, addr_ext[7:0]};
                        ADDR_HIGH: next_prdata = {24'h0, addr_ext[15:8]};
                        ADDR_DATA: next_prdata = {24'h0, nv_byte_data_reg};
                        ADDR_CTRL: next_prdata = {24'h0, nv_access_control_reg};
                        default: next_prdata = RESET_WORD;
                    endcase
                end
            end
            bus_stall: begin
                next_stall_cnt = stall_cnt - 3'h1;
                if (stall_cnt == 3'h1) begin
                    next_state = bus_ready;
                end
            end
            bus_ready: begin
                if (done) begin
                    next_state = bus_idle;
                    next_read_pend = 1'b0;
                    next_start_pend = 1'b0;
                end
            end
            default: next_state = bus_idle;
        endcase
        next_pready = (next_state == bus_ready);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= bus_idle;
            stall_cnt <= 3'h0;
            pready <= 1'b0;
            prdata <= RESET_WORD;
            pslverr <= 1'b0;
            read_pend <= 1'b0;
            start_pend <= 1'b0;
        end else begin
            state <= next_state;
            stall_cnt <= next_stall_cnt;
            pready <= next_pready;
            prdata <= next_prdata;
            pslverr <= next_pslverr;
            read_pend <= next_read_pend;
            start_pend <= next_start_pend;
        end
    end

    // register and programming side
    always_comb begin
        logic [15:0] wide;
        wide = addr_ext;
        next_address = nv_byte_address_reg;
        next_data = nv_byte_data_reg;
        next_mode = program_mode_select;
        next_irq_enable = ready_irq_enable;
        next_arm_cnt = arm_cnt;
        next_busy = program_start_busy;
        next_tick_cnt = tick_cnt;
        next_op_mode = op_mode;
        next_op_addr = op_addr;
        next_op_data = op_data;
        if (arm_cnt != 3'h0) begin
            next_arm_cnt = arm_cnt - 3'h1;
        end
        if (program_start_busy && osc_tick) begin
            next_tick_cnt = tick_cnt - TICK_WIDTH'(1);
            if (commit) begin
                next_busy = 1'b0;
            end
        end
        if (done && pwrite) begin
            if (paddr == ADDR_LOW) begin
                wide[7:0] = pwdata[7:0];
                next_address = wide[ADDR_WIDTH-1:0];
            end
            if (paddr == ADDR_HIGH) begin
                wide[15:8] = pwdata[7:0];
                next_address = wide[ADDR_WIDTH-1:0];
            end
            if (paddr == ADDR_DATA) begin
                next_data = pwdata[7:0];
            end
            if (paddr == ADDR_CTRL) begin
                next_irq_enable = pwdata[CTRL_IRQ_EN_BIT];
                if (!program_start_busy) begin
                    next_mode = program_mode_type'(pwdata[CTRL_MODE_LSB+1:CTRL_MODE_LSB]);
                end
                if (pwdata[CTRL_ARM_BIT]) begin
                    next_arm_cnt = 3'(ARM_WINDOW_CYCLES);
                end
                if (read_pend) begin
                    next_data = mem_rd_data;
                end
                if (start_pend) begin
                    next_busy = 1'b1;
                    next_arm_cnt = 3'h0;
                    next_op_mode = program_mode_type'(pwdata[CTRL_MODE_LSB+1:CTRL_MODE_LSB]);
                    next_op_addr = nv_byte_address_reg;
                    next_op_data = nv_byte_data_reg;
                    if (pwdata[CTRL_MODE_LSB+1:CTRL_MODE_LSB] == mode_erase_write) begin
                        next_tick_cnt = TICK_WIDTH'(ATOMIC_TICKS);
                    end else begin
                        next_tick_cnt = TICK_WIDTH'(SPLIT_OP_TICKS);
                    end
                end
            end
        end
        next_ready_irq = ready_irq_enable && global_irq_enable && !program_start_busy;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nv_byte_address_reg <= '0;
            nv_byte_data_reg <= 8'h00;
            program_mode_select <= mode_erase_write;
            ready_irq_enable <= 1'b0;
            arm_cnt <= 3'h0;
            program_start_busy <= 1'b0;
            tick_cnt <= '0;
            op_mode <= mode_erase_write;
            op_addr <= '0;
            op_data <= 8'h00;
            ready_irq <= 1'b0;
        end else begin
            nv_byte_address_reg <= next_address;
            nv_byte_data_reg <= next_data;
            program_mode_select <= next_mode;
            ready_irq_enable <= next_irq_enable;
            arm_cnt <= next_arm_cnt;
            program_start_busy <= next_busy;
            tick_cnt <= next_tick_cnt;
            op_mode <= next_op_mode;
            op_addr <= next_op_addr;
            op_data <= next_op_data;
            ready_irq <= next_ready_irq;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_read_wait;
        !pready [*4] ##1 pready;
    endsequence
    sequence s_prog_wait;
        !pready [*2] ##1 pready;
    endsequence

    property p_read_stall;
        state == bus_idle && read_ok |=> s_read_wait;
    endproperty
    a_read_stall: assert property (p_read_stall) else $error("read stall not four cycles");

    property p_prog_stall;
        state == bus_idle && start_ok |=> s_prog_wait;
    endproperty
    a_prog_stall: assert property (p_prog_stall) else $error("start stall not two cycles");

    property p_start;
        done && start_pend |=> program_start_busy && tick_cnt != '0;
    endproperty
    a_start: assert property (p_start) else $error("armed start did not begin");

    property p_busy_hold;
        program_start_busy && !commit |=> program_start_busy;
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");

    property p_no_unarmed;
        state == bus_idle && ctrl_setup && pwdata[CTRL_START_BIT] && !program_arm_enable && !program_start_busy
            |=> !start_pend;
    endproperty
    a_no_unarmed: assert property (p_no_unarmed) else $error("unarmed start accepted");

    property p_arm_expire;
        $rose(program_arm_enable) |-> arm_cnt == 3'(ARM_WINDOW_CYCLES);
    endproperty
    a_arm_expire: assert property (p_arm_expire) else $error("arm window wrong length");

    property p_mode_frozen;
        program_start_busy |=> $stable(program_mode_select);
    endproperty
    a_mode_frozen: assert property (p_mode_frozen) else $error("mode changed while busy");

    property p_busy_end_tick;
        $fell(program_start_busy) |-> $past(osc_tick);
    endproperty
    a_busy_end_tick: assert property (p_busy_end_tick) else $error("busy ended off tick");

    property p_no_read_busy;
        program_start_busy |-> !read_ok;
    endproperty
    a_no_read_busy: assert property (p_no_read_busy) else $error("read accepted while busy");

    property p_irq;
        ready_irq_enable && global_irq_enable && !program_start_busy |=> ready_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("ready interrupt missing");
endmodule : eeprom_byte_access_control

// ### nv_cpu_model.sv
`timescale 1ns/100ps
module nv_cpu_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_addr,
    input wire logic [31:0] cmd_wdata,
    output logic cmd_done,
    output logic [31:0] cmd_rdata,
    output logic cmd_err,
    output logic [3:0] waits,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr
);
    // request held until pready; paddr and pwdata inverted on release so stale values never pass
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            psel <= 1'b0;
            penable <= 1'b0;
            pwrite <= 1'b0;
            paddr <= 8'h00;
            pwdata <= 32'h0000_0000;
            cmd_done <= 1'b0;
            cmd_rdata <= 32'h0000_0000;
            cmd_err <= 1'b0;
            waits <= 4'h0;
        end else begin
            cmd_done <= 1'b0;
            if (!psel && cmd_valid) begin
                psel <= 1'b1;
                pwrite <= cmd_write;
                paddr <= cmd_addr;
                pwdata <= cmd_wdata;
                waits <= 4'h0;
            end else if (psel && !penable) begin
                penable <= 1'b1;
            end else if (psel && !pready) begin
                waits <= waits + 4'h1;
            end else if (psel) begin
                psel <= 1'b0;
                penable <= 1'b0;
                cmd_done <= 1'b1;
                cmd_rdata <= prdata;
                cmd_err <= pslverr;
                paddr <= ~paddr;
                pwdata <= ~pwdata;
            end
        end
    end
endmodule : nv_cpu_model

// ### eeprom_byte_access_control_test.sv
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module eeprom_byte_access_control_test import nv_access_pkg::*;;
    // shortened oscillator counts keep the run brief
    localparam int DIV = 2;
    localparam int AT = 20;
    localparam int SP = 10;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic cmd_valid = 1'b0;
    logic cmd_write = 1'b0;
    logic [7:0] cmd_addr = 8'h00;
    logic [31:0] cmd_wdata = 32'h0000_0000;
    logic global_irq_enable = 1'b0;
    logic cmd_done, cmd_err, psel, penable, pwrite, pready, pslverr, ready_irq, er;
    logic [31:0] cmd_rdata, prdata, pwdata, rd, g;
    logic [7:0] paddr;
    logic [3:0] waits, wt;
    logic [31:0] seed = 32'h0000_0034;
    int bad_count = 0;
    int n_tests = 0;
    int cyc = 0;
    int mem [512];
    int mode = 0;
    int ie = 0;
    int a;

    always #(CLK_PERIOD_NS / 2) pclk = ~pclk;
    always @(posedge pclk) cyc <= cyc + 1;

    nv_cpu_model cpu (.pclk(pclk), .presetn(presetn), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_done(cmd_done), .cmd_rdata(cmd_rdata),
        .cmd_err(cmd_err), .waits(waits), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));

    eeprom_byte_access_control #(.OSC_DIV(DIV), .ATOMIC_TICKS(AT), .SPLIT_OP_TICKS(SP)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .global_irq_enable(global_irq_enable), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .ready_irq(ready_irq));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    task automatic wrap_up();
        $display("checks %0d errors %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up

    task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        cmd_valid <= 1'b1;
        cmd_write <= w;
        cmd_addr <= ad;
        cmd_wdata <= d;
        @(posedge pclk);
        cmd_valid <= 1'b0;
        do begin
            @(negedge pclk);
            k++;
        end while (cmd_done !== 1'b1 && k < 100);
        rd = cmd_rdata;
        wt = waits;
        er = cmd_err;
        if (cmd_done !== 1'b1) begin
            bad_count++;
            $display("[ERR] %0t bus transfer never completed", $time);
            wrap_up();
        end
    endtask : bus

    task automatic ctrl(input int bits);
        bus(1'b1, ADDR_CTRL, 32'(mode * 16 + ie * 8 + bits));
    endtask : ctrl

    task automatic wait_idle(output int e);
        int k;
        k = 0;
        do begin
            bus(1'b0, ADDR_CTRL, 32'h0000_0000);
            k++;
        end while (rd[CTRL_START_BIT] !== 1'b0 && k < 200);
        e = cyc;
        if (rd[CTRL_START_BIT] !== 1'b0) begin
            bad_count++;
            $display("[ERR] %0t busy never cleared", $time);
            wrap_up();
        end
    endtask : wait_idle

    task automatic chk_irq(input int busy);
        repeat (2) @(negedge pclk);
        `CHK(ready_irq, (ie != 0 && global_irq_enable && busy == 0))
    endtask : chk_irq

    task automatic set_addr(input int ad);
        bus(1'b1, ADDR_LOW, 32'(ad & 255));
        bus(1'b1, ADDR_HIGH, 32'(ad >> 8));
    endtask : set_addr

    // gap 0 arms at once, 1 never arms, 2 lets the arm window lapse
    task automatic prog_byte(input int m, input int ad, input int d, input int gap);
        int e, t0, n;
        logic s;
        wait_idle(e);
        mode = m;
        ctrl(0);
        set_addr(ad);
        bus(1'b1, ADDR_DATA, 32'(d));
        if (gap != 1) begin
            ctrl(4);
        end
        if (gap == 2) begin
            bus(1'b0, ADDR_CTRL, 32'h0000_0000);
            `CHK(rd, 32'(m * 16 + ie * 8 + 4))
            repeat (6) @(posedge pclk);
        end
        ctrl(2);
        t0 = cyc;
        s = (m != 3 && gap == 0);
        `CHK(wt, 4'(s ? 2 : 0))
        bus(1'b0, ADDR_CTRL, 32'h0000_0000);
        `CHK(rd, 32'(m * 16 + ie * 8 + (s ? 2 : 0)))
        if (!s) begin
            return;
        end
        chk_irq(1);
        // read strobe and mode change while busy are both refused
        mode = m ^ 1;
        ctrl(1);
        mode = m;
        `CHK(wt, 4'h0)
        bus(1'b0, ADDR_CTRL, 32'h0000_0000);
        `CHK(rd, 32'(m * 16 + ie * 8 + 2))
        bus(1'b0, ADDR_DATA, 32'h0000_0000);
        `CHK(rd, 32'(d))
        wait_idle(e);
        n = (m == 0) ? AT : SP;
        `CHK((e - t0 >= (n - 1) * DIV) && (e - t0 <= n * DIV + 10), 1'b1)
        chk_irq(0);
        mem[ad] = (m == 0) ? d : (m == 1) ? 255 : (mem[ad] & d);
    endtask : prog_byte

    task automatic rd_chk(input int ad);
        int e;
        wait_idle(e);
        set_addr(ad);
        ctrl(1);
        `CHK(wt, 4'(READ_STALL_CYCLES))
        bus(1'b0, ADDR_DATA, 32'h0000_0000);
        `CHK(rd, 32'(mem[ad]))
    endtask : rd_chk

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            bus(1'b0, 8'(ADDR_CTRL + 4 * i), 32'h0000_0000);
            `CHK(rd, RESET_WORD)
        end
        foreach (mem[i]) begin
            if (i < 4) begin
                a = (i == 0) ? 0 : (i == 1) ? 'h6c : (i == 2) ? 'h80 : 'hfc;
                bus(1'b1, 8'(a), rnd());
                bus(1'b0, 8'(a), 32'h0000_0000);
                `CHK({rd, er}, {32'h0000_0000, 1'b1})
            end
        end
        bus(1'b1, ADDR_HIGH, 32'h0000_00ff);
        bus(1'b0, ADDR_HIGH, 32'h0000_0000);
        `CHK(rd, 32'h0000_0001)
        bus(1'b1, ADDR_LOW, 32'h0000_01ab);
        bus(1'b0, ADDR_LOW, 32'h0000_0000);
        `CHK(rd, 32'h0000_00ab)
        ie = 1;
        for (int i = 0; i < 4; i++) begin
            g = rnd();
            a = int'(g % 512);
            @(posedge pclk);
            global_irq_enable <= g[9];
            prog_byte(1, a, int'(rnd() & 255), 0);
            rd_chk(a);
            prog_byte(2, a, int'(rnd() & 255), 0);
            rd_chk(a);
            prog_byte(0, a, int'(rnd() & 255), 0);
            rd_chk(a);
            prog_byte(3, a, int'(rnd() & 255), 0);
            prog_byte(0, a, int'(rnd() & 255), 1);
            prog_byte(0, a, int'(rnd() & 255), 2);
            rd_chk(a);
        end
        // reset during a running erase clears all control state
        mode = 1;
        ctrl(4);
        ctrl(2);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        bus(1'b0, ADDR_CTRL, 32'h0000_0000);
        `CHK(rd, RESET_WORD)
        wrap_up();
    end

    initial begin
        #400000;
        bad_count++;
        $display("[ERR] %0t watchdog expired", $time);
        wrap_up();
    end
endmodule : eeprom_byte_access_control_test
